// ==== shared/usr_cfg.svh ====
// register map, field positions and reset values of the synchronous usart
`ifndef USR_CFG_SVH
`define USR_CFG_SVH

`define USR_ADDR_RCSTA   3'h0
`define USR_ADDR_RCBUF   3'h1
`define USR_ADDR_TXSTA   3'h2
`define USR_ADDR_BAUDCON 3'h3
`define USR_ADDR_BRGH    3'h4
`define USR_ADDR_BRGL    3'h5
`define USR_ADDR_TXBUF   3'h6
`define USR_ADDR_INTCTL  3'h7

`define USR_RC_SERIAL_PORT_ENABLE  7
`define USR_RC_RX9   6
`define USR_RC_SINGLE_WORD_RECEIVE_ENABLE  5
`define USR_RC_CONTINUOUS_RECEIVE_ENABLE  4
`define USR_RC_FRAMING_ERROR_FLAG  2
`define USR_RC_OVERRUN_ERROR_FLAG  1
`define USR_RC_RECEIVED_NINTH_BIT  0

`define USR_TX_CLOCK_SOURCE_SELECT  7
`define USR_TX_TX9   6
`define USR_TX_TRANSMIT_ENABLE_BIT  5
`define USR_TX_SYNC  4
`define USR_TX_BRGH  2
`define USR_TX_SHIFT_REGISTER_EMPTY  1
`define USR_TX_TRANSMIT_NINTH_BIT  0

`define USR_BC_CLOCK_IDLE_POLARITY 4
`define USR_BC_WIDE_DIVISOR_SELECT 3

`define USR_IC_RCIE  0
`define USR_IC_TXIE  1
`define USR_IC_RCIF  4
`define USR_IC_TXIF  5

`define USR_TXIF_RST 1'b1
`define USR_LEN8     4'h8
`define USR_LEN9     4'h9

`endif

// ==== shared/usr_pkg.sv ====
// types of the synchronous usart
package usr_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } usr_bus_t;

  typedef struct packed {
    logic ck_o;
    logic ck_oe;
    logic dt_o;
    logic dt_oe;
  } usr_pin_out_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
  } usr_sync_t;

  typedef struct packed {
    logic serial_port_enable, rx9, single_word_receive_enable, continuous_receive_enable, overrun_error_flag, received_ninth_bit;
    logic clock_source_select, tx9, transmit_enable_bit, sync, brgh, transmit_ninth_bit;
    logic clock_idle_polarity, wide_divisor_select, rcie, txie;
    logic [7:0]  div_hi;
    logic [7:0]  div_lo;
    logic [7:0]  rcbuf;
    logic        rcif;
    logic [7:0]  txbuf;
    logic        txbuf_full;
    logic        txif;
    logic [8:0]  transmit_shift_register;
    logic        tsr_full;
    logic [3:0]  tx_cnt;
    logic [8:0]  receive_shift_register;
    logic [3:0]  rx_cnt;
    logic [15:0] baud_cnt;
    logic        ck_prev;
    logic [7:0]  rdata;
    usr_pin_out_t pins;
    logic        rx_irq;
    logic        tx_irq;
    logic        wake;
  } usr_state_t;

endpackage

// ==== logic/usr_sync.sv ====
// three-stage synchroniser with agreement filter for clock and data pins
`timescale 1ns/100ps
`default_nettype none
module usr_sync (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);
  usr_pkg::usr_sync_t s_r;
  usr_pkg::usr_sync_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // per bit, accept a level only once stages two and three agree
    for (int i = 0; i < 2; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.filt[i] = s_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.filt;
endmodule // usr_sync
`default_nettype wire

// ==== logic/usr_top.sv ====
// synchronous usart: master/slave receive, master/slave transmit, register port
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "usr_cfg.svh"
module usr_top (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire usr_pkg::usr_bus_t    bus,
  output logic                [7:0] rdata,
  input  wire logic                 low_power,
  input  wire logic                 ck_i,
  input  wire logic                 dt_i,
  output usr_pkg::usr_pin_out_t     pins,
  output logic                      rx_irq,
  output logic                      tx_irq,
  output logic                      wake
);
  usr_pkg::usr_state_t s_r;
  usr_pkg::usr_state_t s_nxt;

  logic [1:0]  pin_f;
  logic        ck_f;
  logic        dt_f;
  logic        master;
  logic        slave;
  logic        rx_mode;
  logic        rx_run;
  logic        tx_run;
  logic        clk_run;
  logic        tick;
  logic        fall;
  logic        rx_done;
  logic        rx_free;
  logic        tx_load;
  logic        rc_set;
  logic        tx_set;
  logic        wr_rcsta;
  logic        wr_txbuf;
  logic        rd_rcbuf;
  logic [3:0]  rx_len;
  logic [3:0]  tx_len;
  logic [15:0] baud_term;
  logic [8:0]  rsr_v;

  usr_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .din  ({dt_i, ck_i}),
    .dout (pin_f)
  );
  assign ck_f = pin_f[0];
  assign dt_f = pin_f[1];

  always_comb begin
    s_nxt      = s_r;
    s_nxt.wake = 1'b0;
    rsr_v      = s_r.receive_shift_register;
    wr_rcsta   = bus.wr && (bus.addr == `USR_ADDR_RCSTA);
    wr_txbuf   = bus.wr && (bus.addr == `USR_ADDR_TXBUF);
    rd_rcbuf   = bus.rd && (bus.addr == `USR_ADDR_RCBUF);
    master     = s_r.serial_port_enable && s_r.sync && s_r.clock_source_select;
    slave      = s_r.serial_port_enable && s_r.sync && !s_r.clock_source_select;
    // receive enables, single ignored in slave
    rx_mode    = s_r.serial_port_enable && s_r.sync &&
                 (s_r.continuous_receive_enable || (s_r.single_word_receive_enable && s_r.clock_source_select));
    rx_run     = rx_mode && !s_r.overrun_error_flag;
    tx_run     = s_r.serial_port_enable && s_r.sync && s_r.transmit_enable_bit && !rx_mode;
    rx_len     = s_r.rx9 ? `USR_LEN9 : `USR_LEN8;
    tx_len     = s_r.tx9 ? `USR_LEN9 : `USR_LEN8;
    baud_term  = s_r.wide_divisor_select ? {s_r.div_hi, s_r.div_lo}
                           : {8'h00, s_r.div_lo};

    // master clock stops with the core in low power
    clk_run = master && !low_power &&
              (rx_run || s_r.tsr_full || (s_r.pins.ck_o != s_r.clock_idle_polarity));
    tick = clk_run && (s_r.baud_cnt == baud_term);
    if (!clk_run) begin
      s_nxt.baud_cnt = 16'h0000;
      if (!master) begin
        // idle level of the clock line
        s_nxt.pins.ck_o = s_r.clock_idle_polarity;
      end
    end else if (tick) begin
      s_nxt.baud_cnt  = 16'h0000;
      s_nxt.pins.ck_o = ~s_r.pins.ck_o;
    end else begin
      s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
    end
    s_nxt.pins.ck_oe = master;
    s_nxt.ck_prev    = ck_f;
    // shifting happens on falling edges only
    fall = master ? (tick && s_r.pins.ck_o)
                  : (slave && s_r.ck_prev && !ck_f);

    // software writes to control state
    if (wr_rcsta) begin
      s_nxt.serial_port_enable = bus.wdata[`USR_RC_SERIAL_PORT_ENABLE];
      s_nxt.rx9  = bus.wdata[`USR_RC_RX9];
      s_nxt.single_word_receive_enable = bus.wdata[`USR_RC_SINGLE_WORD_RECEIVE_ENABLE];
      s_nxt.continuous_receive_enable = bus.wdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE];
      // dropping the continuous enable clears the error
      if (s_r.continuous_receive_enable && !bus.wdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
        s_nxt.overrun_error_flag = 1'b0;
      end
    end
    if (bus.wr && (bus.addr == `USR_ADDR_TXSTA)) begin
      s_nxt.clock_source_select = bus.wdata[`USR_TX_CLOCK_SOURCE_SELECT];
      s_nxt.tx9  = bus.wdata[`USR_TX_TX9];
      s_nxt.transmit_enable_bit = bus.wdata[`USR_TX_TRANSMIT_ENABLE_BIT];
      s_nxt.sync = bus.wdata[`USR_TX_SYNC];
      s_nxt.brgh = bus.wdata[`USR_TX_BRGH];
      s_nxt.transmit_ninth_bit = bus.wdata[`USR_TX_TRANSMIT_NINTH_BIT];
    end
    if (bus.wr && (bus.addr == `USR_ADDR_BAUDCON)) begin
      s_nxt.clock_idle_polarity = bus.wdata[`USR_BC_CLOCK_IDLE_POLARITY];
      s_nxt.wide_divisor_select = bus.wdata[`USR_BC_WIDE_DIVISOR_SELECT];
    end
    if (bus.wr && (bus.addr == `USR_ADDR_BRGH)) begin
      s_nxt.div_hi = bus.wdata;
    end
    if (bus.wr && (bus.addr == `USR_ADDR_BRGL)) begin
      s_nxt.div_lo = bus.wdata;
    end
    if (bus.wr && (bus.addr == `USR_ADDR_INTCTL)) begin
      s_nxt.rcie = bus.wdata[`USR_IC_RCIE];
      s_nxt.txie = bus.wdata[`USR_IC_TXIE];
    end
    // reading the data byte frees the buffer
    if (rd_rcbuf) begin
      s_nxt.rcif = 1'b0;
    end

    // receive engine
    rx_done = 1'b0;
    rx_free = !s_r.rcif || rd_rcbuf;
    rc_set  = 1'b0;
    if (!rx_run) begin
      s_nxt.rx_cnt = 4'h0;
    end else if (fall) begin
      rsr_v[s_r.rx_cnt] = dt_f;
      s_nxt.receive_shift_register         = rsr_v;
      s_nxt.rx_cnt      = s_r.rx_cnt + 4'h1;
      if ((s_r.rx_cnt + 4'h1) == rx_len) begin
        rx_done      = 1'b1;
        s_nxt.rx_cnt = 4'h0;
        if (rx_free) begin
          // word moves to buffer, ninth bit kept
          s_nxt.rcbuf = rsr_v[7:0];
          s_nxt.received_ninth_bit  = s_r.rx9 && rsr_v[8];
          // set wins over a read in the same cycle
          s_nxt.rcif  = 1'b1;
          rc_set      = 1'b1;
        end else begin
          // unread word still held: new one is dropped
          s_nxt.overrun_error_flag = 1'b1;
        end
        // single word clears itself, continuous keeps on
        if (!s_r.continuous_receive_enable) begin
          s_nxt.single_word_receive_enable = 1'b0;
        end
      end
    end

    // transmit engine
    tx_load = 1'b0;
    tx_set  = 1'b0;
    if (!(s_r.serial_port_enable && s_r.sync && s_r.transmit_enable_bit)) begin
      s_nxt.tsr_full = 1'b0;
      s_nxt.tx_cnt   = 4'h0;
    end else if (tx_run && !s_r.tsr_full && s_r.txbuf_full) begin
      // buffer moves to shifter, flag sets
      tx_load          = 1'b1;
      s_nxt.transmit_shift_register        = {s_r.tx9 && s_r.transmit_ninth_bit, s_r.txbuf};
      s_nxt.tsr_full   = 1'b1;
      s_nxt.tx_cnt     = 4'h0;
      s_nxt.txbuf_full = 1'b0;
      s_nxt.txif       = 1'b1;
      s_nxt.pins.dt_o  = s_r.txbuf[0];
      tx_set           = 1'b1;
    end else if (tx_run && s_r.tsr_full && fall) begin
      // same shifting in master and slave
      s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
      if ((s_r.tx_cnt + 4'h1) == tx_len) begin
        s_nxt.tsr_full = 1'b0;
        s_nxt.tx_cnt   = 4'h0;
      end else begin
        s_nxt.pins.dt_o = s_r.transmit_shift_register[s_r.tx_cnt + 4'h1];
      end
    end
    s_nxt.pins.dt_oe = tx_run;
    // a write refills the buffer and clears the flag
    if (wr_txbuf) begin
      s_nxt.txbuf      = bus.wdata;
      s_nxt.txbuf_full = 1'b1;
      s_nxt.txif       = 1'b0;
    end

    s_nxt.rx_irq = s_nxt.rcif && s_nxt.rcie;
    s_nxt.tx_irq = s_nxt.txif && s_nxt.txie;
    // flag events with their interrupt enabled during low power wake the system
    s_nxt.wake = low_power &&
                 ((rc_set && s_r.rcie) || (tx_set && s_r.txie));

    // read port, one cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `USR_ADDR_RCSTA: begin
          s_nxt.rdata[`USR_RC_SERIAL_PORT_ENABLE] = s_r.serial_port_enable;
          s_nxt.rdata[`USR_RC_RX9]  = s_r.rx9;
          s_nxt.rdata[`USR_RC_SINGLE_WORD_RECEIVE_ENABLE] = s_r.single_word_receive_enable;
          s_nxt.rdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE] = s_r.continuous_receive_enable;
          s_nxt.rdata[`USR_RC_OVERRUN_ERROR_FLAG] = s_r.overrun_error_flag;
          s_nxt.rdata[`USR_RC_RECEIVED_NINTH_BIT] = s_r.received_ninth_bit;
        end
        `USR_ADDR_RCBUF: begin
          s_nxt.rdata = s_r.rcbuf;
        end
        `USR_ADDR_TXSTA: begin
          s_nxt.rdata[`USR_TX_CLOCK_SOURCE_SELECT] = s_r.clock_source_select;
          s_nxt.rdata[`USR_TX_TX9]  = s_r.tx9;
          s_nxt.rdata[`USR_TX_TRANSMIT_ENABLE_BIT] = s_r.transmit_enable_bit;
          s_nxt.rdata[`USR_TX_SYNC] = s_r.sync;
          s_nxt.rdata[`USR_TX_BRGH] = s_r.brgh;
          s_nxt.rdata[`USR_TX_SHIFT_REGISTER_EMPTY] = !s_r.tsr_full;
          s_nxt.rdata[`USR_TX_TRANSMIT_NINTH_BIT] = s_r.transmit_ninth_bit;
        end
        `USR_ADDR_BAUDCON: begin
          s_nxt.rdata[`USR_BC_CLOCK_IDLE_POLARITY] = s_r.clock_idle_polarity;
          s_nxt.rdata[`USR_BC_WIDE_DIVISOR_SELECT] = s_r.wide_divisor_select;
        end
        `USR_ADDR_BRGH: begin
          s_nxt.rdata = s_r.div_hi;
        end
        `USR_ADDR_BRGL: begin
          s_nxt.rdata = s_r.div_lo;
        end
        `USR_ADDR_TXBUF: begin
          s_nxt.rdata = s_r.txbuf;
        end
        `USR_ADDR_INTCTL: begin
          s_nxt.rdata[`USR_IC_RCIE] = s_r.rcie;
          s_nxt.rdata[`USR_IC_TXIE] = s_r.txie;
          s_nxt.rdata[`USR_IC_RCIF] = s_r.rcif;
          s_nxt.rdata[`USR_IC_TXIF] = s_r.txif;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r      <= '0;
      s_r.txif <= `USR_TXIF_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata  = s_r.rdata;
  assign pins   = s_r.pins;
  assign rx_irq = s_r.rx_irq;
  assign tx_irq = s_r.tx_irq;
  assign wake   = s_r.wake;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  rx_flag_set_a : assert property (
    rx_done |=> (s_r.rcif || s_r.overrun_error_flag))
    else $error("completed word set neither flag nor error");

  single_word_stop_a : assert property (
    (rx_done && s_r.clock_source_select && !s_r.continuous_receive_enable && !wr_rcsta) |=> !s_r.single_word_receive_enable)
    else $error("single-word enable still set after one word");

  cont_keep_a : assert property (
    (rx_done && s_r.continuous_receive_enable && !wr_rcsta) |=> (s_r.continuous_receive_enable && rx_mode))
    else $error("continuous reception stopped on its own");

  slave_single_word_receive_enable_a : assert property (
    (slave && s_r.single_word_receive_enable && !s_r.continuous_receive_enable) |-> (!rx_mode && s_r.rx_cnt == 4'h0))
    else $error("slave reception started by single-word enable");

  err_clear_a : assert property (
    (wr_rcsta && s_r.continuous_receive_enable && !bus.wdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE]) |=> !s_r.overrun_error_flag)
    else $error("error kept after continuous enable cleared");

  txif_move_a : assert property (
    (tx_load && !wr_txbuf) |=> (s_r.txif && s_r.tsr_full && !s_r.txbuf_full))
    else $error("buffer move did not set flag and load shifter");

  txif_write_a : assert property (
    wr_txbuf |=> (!s_r.txif && s_r.txbuf_full))
    else $error("buffer write did not clear the empty flag");

  shift_register_empty_read_a : assert property (
    (bus.rd && bus.addr == `USR_ADDR_TXSTA)
      |=> (rdata[`USR_TX_SHIFT_REGISTER_EMPTY] == !$past(s_r.tsr_full)))
    else $error("shifter empty status wrong");

  half_duplex_a : assert property (
    rx_mode ##1 rx_mode |-> (!pins.dt_oe && s_r.tx_cnt == $past(s_r.tx_cnt)))
    else $error("transmit active during reception");

  ck_idle_a : assert property (
    (!master ##1 !master) |-> (pins.ck_o == $past(s_r.clock_idle_polarity)))
    else $error("clock not at idle level");

  rx_irq_a : assert property (
    (s_r.rcif && s_r.rcie) ##1 (s_r.rcif && s_r.rcie) |-> rx_irq)
    else $error("receive interrupt not raised");

  wake_a : assert property (
    (low_power && rc_set && s_r.rcie) |=> wake)
    else $error("no wake-up on reception in low power");

  single_word_c : cover property (rx_done && s_r.single_word_receive_enable && !s_r.continuous_receive_enable);
  tx_load_c     : cover property (tx_load ##[1:400] tx_load);
  overrun_c     : cover property (rx_done && !rx_free);
  slave_wake_c  : cover property (slave && low_power && rc_set);
endmodule // usr_top
`default_nettype wire

// ==== testbench/usr_peer.sv ====
// behavioural serial peer on the shift clock and data lines
`timescale 1ns/100ps
`default_nettype none
module usr_peer (
  input  wire logic clk,
  input  wire logic ck,
  input  wire logic dt,
  output logic      ck_drv,
  output logic      dt_drv
);
  logic [8:0] word;
  logic [8:0] got;
  logic [3:0] idx;
  logic [3:0] nb;
  logic       talk;
  logic       wob;
  logic       bit_q;
  initial begin
    ck_drv = 1'h0;
    wob    = 1'h0;
    bit_q  = 1'h0;
    talk   = 1'h0;
    nb     = 4'h8;
    idx    = 4'h0;
  end
  // released line wobbles so stale data never looks valid
  always @(posedge clk) wob <= ~wob;
  // new bit on rise, held across the fall
  always @(posedge ck) begin
    got[idx] <= dt;
    bit_q    <= word[idx];
  end
  assign dt_drv = talk ? bit_q : wob;
  always @(negedge ck) idx <= (idx == nb - 4'h1) ? 4'h0 : idx + 4'h1;
  task start(input logic [8:0] w, input logic [3:0] n, input logic t);
    word = w;
    nb   = n;
    idx  = 4'h0;
    got  = 9'h000;
    talk = t;
  endtask
  // peer supplies the clock, still between frames
  task slave(input int n);
    #7.3;
    repeat (n) begin
      #62.5 ck_drv = 1'h1;
      #62.5 ck_drv = 1'h0;
    end
  endtask
endmodule // usr_peer
`default_nettype wire

// ==== testbench/usart_synchronous_rx_and_slave_tb.sv ====
// self-checking bench of the synchronous usart
`timescale 1ns/100ps
`default_nettype none
`include "usr_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module usart_synchronous_rx_and_slave_tb;
  logic                  clk;
  logic                  srst;
  logic                  low_power;
  usr_pkg::usr_bus_t     bus;
  logic [7:0]            rdata;
  usr_pkg::usr_pin_out_t pins;
  logic                  rx_irq;
  logic                  tx_irq;
  logic                  wake;
  logic                  ck_i;
  logic                  dt_i;
  logic                  peer_ck;
  logic                  peer_dt;
  logic [7:0]            r;
  int                    num_errors;
  int                    total_checks;
  int                    cycles;
  int                    wake_cnt;
  int                    flips;

  // wire level from whoever drives each pin
  assign ck_i = pins.ck_oe ? pins.ck_o : peer_ck;
  assign dt_i = pins.dt_oe ? pins.dt_o : peer_dt;

  usr_top DUT (
    .clk       (clk),
    .srst      (srst),
    .bus       (bus),
    .rdata     (rdata),
    .low_power (low_power),
    .ck_i      (ck_i),
    .dt_i      (dt_i),
    .pins      (pins),
    .rx_irq    (rx_irq),
    .tx_irq    (tx_irq),
    .wake      (wake)
  );
  usr_peer peer (
    .clk    (clk),
    .ck     (ck_i),
    .dt     (dt_i),
    .ck_drv (peer_ck),
    .dt_drv (peer_dt)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ceiling well above the fewer than two thousand cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  always @(posedge clk) begin
    if (srst) wake_cnt <= 0;
    else if (wake === 1'h1) wake_cnt <= wake_cnt + 1;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clk);
    bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 r = rdata;
  endtask
  task rst;
    srst      <= 1'h1;
    low_power <= 1'h0;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
  endtask
  task wait_rx;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (rx_irq === 1'h1) break;
    end
  endtask
  task pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task t_regs;
    rst;
    rd(`USR_ADDR_INTCTL);
    `CHK(r, 8'h20)
    rd(`USR_ADDR_TXSTA);
    `CHK(r, 8'h02)
    wr(`USR_ADDR_BRGH, 8'hA5);
    rd(`USR_ADDR_BRGH);
    `CHK(r, 8'hA5)
    wr(`USR_ADDR_BAUDCON, 8'hFF);
    rd(`USR_ADDR_BAUDCON);
    `CHK(r, 8'h18)
    wr(`USR_ADDR_INTCTL, 8'hFF);
    rd(`USR_ADDR_INTCTL);
    `CHK(r, 8'h23)
    `CHK(tx_irq, 1'h1)
    $display("test regs done");
  endtask
  // master, single word, then the clock must rest
  task t_master_single;
    rst;
    peer.start(9'h0A5, 4'h8, 1'h1);
    wr(`USR_ADDR_BRGL, 8'h07);
    wr(`USR_ADDR_TXSTA, 8'h90);
    wr(`USR_ADDR_INTCTL, 8'h01);
    wr(`USR_ADDR_RCSTA, 8'hA0);
    wait_rx;
    `CHK(rx_irq, 1'h1)
    rd(`USR_ADDR_RCSTA);
    `CHK(r, 8'h80)
    rd(`USR_ADDR_RCBUF);
    `CHK(r, 8'hA5)
    flips = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (pins.ck_o !== 1'h0) flips++;
    end
    `CHK(flips, 0)
    `CHK(rx_irq, 1'h0)
    $display("test master single done");
  endtask
  // both enables, nine bits, two words then overrun and recovery
  task t_master_cont;
    rst;
    peer.start(9'h1C3, 4'h9, 1'h1);
    wr(`USR_ADDR_BRGL, 8'h07);
    wr(`USR_ADDR_TXSTA, 8'h90);
    // wait_rx needs the receive interrupt line
    wr(`USR_ADDR_INTCTL, 8'h01);
    wr(`USR_ADDR_RCSTA, 8'hF0);
    repeat (2) begin
      wait_rx;
      rd(`USR_ADDR_RCSTA);
      `CHK(r, 8'hF1)
      rd(`USR_ADDR_RCBUF);
      `CHK(r, 8'hC3)
    end
    pause(400);
    rd(`USR_ADDR_RCSTA);
    `CHK(r, 8'hF3)
    wr(`USR_ADDR_RCSTA, 8'hC0);
    rd(`USR_ADDR_RCSTA);
    `CHK(r[1], 1'h0)
    rd(`USR_ADDR_RCBUF);
    `CHK(r, 8'hC3)
    $display("test master continuous done");
  endtask
  // slave receive: single enable ignored, continuous works in sleep
  task t_slave_rx;
    rst;
    wr(`USR_ADDR_TXSTA, 8'h10);
    wr(`USR_ADDR_INTCTL, 8'h01);
    wr(`USR_ADDR_RCSTA, 8'hA0);
    peer.start(9'h03C, 4'h8, 1'h1);
    peer.slave(8);
    pause(20);
    rd(`USR_ADDR_INTCTL);
    `CHK(r, 8'h21)
    wr(`USR_ADDR_RCSTA, 8'h90);
    low_power <= 1'h1;
    peer.start(9'h03C, 4'h8, 1'h1);
    peer.slave(8);
    pause(20);
    `CHK(wake_cnt, 1)
    `CHK(rx_irq, 1'h1)
    rd(`USR_ADDR_RCBUF);
    `CHK(r, 8'h3C)
    low_power <= 1'h0;
    $display("test slave receive done");
  endtask
  // slave transmit of two words queued before sleep
  task t_slave_tx;
    rst;
    wr(`USR_ADDR_RCSTA, 8'h80);
    wr(`USR_ADDR_TXSTA, 8'h30);
    wr(`USR_ADDR_INTCTL, 8'h02);
    wr(`USR_ADDR_TXBUF, 8'h5A);
    wr(`USR_ADDR_TXBUF, 8'h96);
    // sleep only after both words are queued
    low_power <= 1'h1;
    pause(3);
    `CHK(pins.dt_oe, 1'h1)
    rd(`USR_ADDR_INTCTL);
    `CHK(r, 8'h02)
    rd(`USR_ADDR_TXSTA);
    `CHK(r, 8'h30)
    peer.start(9'h000, 4'h8, 1'h0);
    peer.slave(8);
    pause(20);
    `CHK(peer.got[7:0], 8'h5A)
    rd(`USR_ADDR_INTCTL);
    `CHK(r, 8'h22)
    `CHK(wake_cnt, 1)
    `CHK(tx_irq, 1'h1)
    peer.start(9'h000, 4'h8, 1'h0);
    peer.slave(8);
    pause(20);
    `CHK(peer.got[7:0], 8'h96)
    rd(`USR_ADDR_TXSTA);
    `CHK(r, 8'h32)
    wr(`USR_ADDR_RCSTA, 8'h90);
    pause(3);
    `CHK(pins.dt_oe, 1'h0)
    $display("test slave transmit done");
  endtask
  task t_polarity;
    rst;
    wr(`USR_ADDR_BRGL, 8'h07);
    wr(`USR_ADDR_TXSTA, 8'h90);
    wr(`USR_ADDR_BAUDCON, 8'h10);
    wr(`USR_ADDR_RCSTA, 8'h80);
    pause(40);
    `CHK(pins.ck_oe, 1'h1)
    `CHK(pins.ck_o, 1'h1)
    wr(`USR_ADDR_BAUDCON, 8'h00);
    pause(40);
    `CHK(pins.ck_o, 1'h0)
    $display("test polarity done");
  endtask

  initial begin
    srst         = 1'h1;
    low_power    = 1'h0;
    bus          = '0;
    num_errors   = 0;
    total_checks = 0;
    cycles       = 0;
    t_regs;
    t_master_single;
    t_master_cont;
    t_slave_rx;
    t_slave_tx;
    t_polarity;
    end_of_test;
  end
endmodule // usart_synchronous_rx_and_slave_tb
`default_nettype wire
